// ===== core/ssc_ctrl_words.sv
/*
  Serial control-word decoder for the IF/oscillator word, the test word and the IF feedback counters.
  Assumes three serial pins from an outside host and the default-counter selection bit from on-chip logic.
*/
// How it works
// - Each word is 24 bits, shifted in most significant bit first, with the address in the low bits.
// - A word ending in binary 10 with no longer code matching loads the IF and oscillator controls.
// - Bit 2 of that word powers the IF synthesizer down at 0 and up at 1.
// - Bits 4:3 choose charge-pump gain of 100, 200, 300 or 800 uA.
// - Bits 6:5 choose the fixed IF of 170.76, 367.20 or 440.76 MHz.
// - Bit 7 chooses a 19.20 MHz reference at 0 and 19.68 MHz at 1.
// - Bits 9:8 scale VCO current from minimum to maximum, and the host should write 11.
// - A word ending in binary 011 goes to the test word.
// - Test-word writes take effect only while default-counter selection is 0.
// - A word ending in binary 0111 goes to the IF feedback counters.
// - The feedback counters are used only while default-counter selection is 0.
// - The counter word holds a 9-bit B field above the address and a 4-bit A field above that.
// - Default-counter selection at 1 means built-in IF counters, at 0 means user counters once a feedback counter word has been loaded.
`timescale 1ns/10ps

module ssc_ctrl_words import ssc_pkg::*; (
  // Clock, reset and enable
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CE,
  // Serial pins from the host
  input wire logic SER_CLK,
  input wire logic SER_DATA,
  input wire logic SER_LATCH,
  // Selection bit from the first word
  input wire logic DEFAULT_COUNTER_SELECT,
  // IF and oscillator controls
  output ssc_if_ctrl_type IF_CTRL,
  // Test word
  output logic [`SSC_WORD_W-1:0] TEST_WORD,
  output logic TEST_WORD_VALID,
  output logic TEST_PATTERN_OK,
  // Feedback counters
  output ssc_fb_count_type FB_COUNT,
  output logic FB_COUNT_OVERRIDE,
  // Write strobes
  output logic WRITE_IF_OSC,
  output logic WRITE_TEST,
  output logic WRITE_FB
);

  localparam ssc_state_type RESET_STATE = '{
    sclk_q: 1'b0,
    le_q: 1'b1, // Idle latch level
    shift: '0,
    ctrl: '{if_enable: `SSC_IF_EN_RESET, if_pump_gain_sel: `SSC_GAIN_RESET,
            fixed_if_select: `SSC_FIXED_IF_RESET, ref_osc_select: `SSC_REF_OSC_RESET,
            vco_drive_level: `SSC_VCO_RESET},
    test_word: `SSC_TEST_RESET,
    test_valid: 1'b0,
    fb: '{a_count: `SSC_A_RESET, b_count: `SSC_B_RESET},
    fb_loaded: 1'b0,
    wr_if_osc: 1'b0,
    wr_test: 1'b0,
    wr_fb: 1'b0,
    last_target: SSC_TGT_NONE
  };

  logic [1:0] rst_pipe;
  logic rst_n;
  logic [2:0] pins_s;
  logic sclk_s;
  logic data_s;
  logic le_s;
  logic sclk_rise;
  logic le_rise;
  ssc_target_type target;
  ssc_state_type st;
  ssc_state_type next_st;

  // Reset release through two flops; not gated by CE so reset always completes
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe[1];

  // Pins cross into CLK before anything looks at them
  ssc_pin_sync #(.WIDTH(3)) u_pin_sync (
    .clk(CLK),
    .rst_n(rst_n),
    .ce(CE),
    .pin_in({SER_CLK, SER_DATA, ~SER_LATCH}),
    .pin_sync(pins_s)
  );
  assign sclk_s = pins_s[2];
  assign data_s = pins_s[1];
  // Latch idles high and crosses inverted, so cleared flops match it and no false rise follows reset
  assign le_s = ~pins_s[0];

  // Edge detection on synchronised copies; serial clock must stay well below CLK/4
  assign sclk_rise = CE & sclk_s & ~st.sclk_q;
  assign le_rise = CE & le_s & ~st.le_q;

  // Longest code checked first so 01111 and 0111 never fall through to 011
  function automatic ssc_target_type decode_addr(input logic [`SSC_WORD_W-1:0] w);
    ssc_target_type t;
    t = SSC_TGT_NONE;
    if (w[`SSC_FB_ADDR_W-1:0] == `SSC_FB_ADDR) begin
      t = SSC_TGT_FB;
    end else if (w[`SSC_TEST_ADDR_W-1:0] == `SSC_TEST_ADDR) begin
      t = SSC_TGT_TEST;
    end else if (w[`SSC_IF_OSC_ADDR_W-1:0] == `SSC_IF_OSC_ADDR) begin
      t = SSC_TGT_IF_OSC;
    end
    return t;
  endfunction : decode_addr

  assign target = decode_addr(st.shift);

  // Next state: shift while latch low, decode on latch rise
  always_comb begin
    next_st = st;
    next_st.sclk_q = sclk_s;
    next_st.le_q = le_s;
    next_st.wr_if_osc = 1'b0;
    next_st.wr_test = 1'b0;
    next_st.wr_fb = 1'b0;
    if (sclk_rise && !le_s) begin
      next_st.shift = {st.shift[`SSC_WORD_MSB-1:0], data_s};
    end
    if (le_rise) begin
      next_st.last_target = target;
      case (target)
        SSC_TGT_IF_OSC: begin
          next_st.wr_if_osc = 1'b1;
          next_st.ctrl.if_enable = st.shift[`SSC_IF_EN_BIT];
          next_st.ctrl.if_pump_gain_sel = st.shift[`SSC_GAIN_LSB +: 2];
          next_st.ctrl.fixed_if_select = st.shift[`SSC_FIXED_IF_LSB +: 2];
          next_st.ctrl.ref_osc_select = st.shift[`SSC_REF_OSC_BIT];
          next_st.ctrl.vco_drive_level = st.shift[`SSC_VCO_LSB +: 2];
        end
        SSC_TGT_TEST: begin
          // Ignored outright while built-in counters are selected
          if (!DEFAULT_COUNTER_SELECT) begin
            next_st.wr_test = 1'b1;
            next_st.test_word = st.shift;
            next_st.test_valid = 1'b1;
          end
        end
        SSC_TGT_FB: begin
          if (!DEFAULT_COUNTER_SELECT) begin
            next_st.wr_fb = 1'b1;
            next_st.fb.b_count = st.shift[`SSC_B_LSB +: `SSC_B_W];
            next_st.fb.a_count = st.shift[`SSC_A_LSB +: `SSC_A_W];
            next_st.fb_loaded = 1'b1;
          end
        end
        default: begin
          next_st.last_target = SSC_TGT_NONE;
        end
      endcase
    end
  end

  // State register; CE low holds everything
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      st <= RESET_STATE;
    end else if (CE) begin
      st <= next_st;
    end
  end

  // Outputs straight from state, except the override, which is also gated by the selection bit
  assign IF_CTRL = st.ctrl;
  assign TEST_WORD = st.test_word;
  assign TEST_WORD_VALID = st.test_valid;
  assign TEST_PATTERN_OK = st.test_valid & (st.test_word == `SSC_TEST_PATTERN);
  assign FB_COUNT = st.fb;
  // Built-in counters win whenever the selection bit is set
  assign FB_COUNT_OVERRIDE = st.fb_loaded & ~DEFAULT_COUNTER_SELECT;
  assign WRITE_IF_OSC = st.wr_if_osc;
  assign WRITE_TEST = st.wr_test;
  assign WRITE_FB = st.wr_fb;

  // Checks on decode and field loading
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!rst_n);

  a_word_shift: assert property (
    sclk_rise && !le_s |=> st.shift == {$past(st.shift[`SSC_WORD_MSB-1:0]), $past(data_s)})
    else $error("serial bit not shifted into the word");

  a_if_osc_route: assert property (
    le_rise && st.shift[1:0] == 2'h2 |=> WRITE_IF_OSC && !WRITE_TEST && !WRITE_FB)
    else $error("word ending in 10 not routed to IF control");

  a_if_enable_load: assert property (
    le_rise && target == SSC_TGT_IF_OSC |=> IF_CTRL.if_enable == $past(st.shift[2]))
    else $error("IF enable not loaded from bit 2");

  a_pump_gain_load: assert property (
    le_rise && target == SSC_TGT_IF_OSC |=> IF_CTRL.if_pump_gain_sel == $past(st.shift[4:3]))
    else $error("pump gain not loaded from bits 4:3");

  a_fixed_if_load: assert property (
    le_rise && target == SSC_TGT_IF_OSC |=> IF_CTRL.fixed_if_select == $past(st.shift[6:5]))
    else $error("fixed IF not loaded from bits 6:5");

  a_ref_osc_load: assert property (
    le_rise && target == SSC_TGT_IF_OSC |=> IF_CTRL.ref_osc_select == $past(st.shift[7]))
    else $error("reference select not loaded from bit 7");

  a_vco_level_load: assert property (
    le_rise && target == SSC_TGT_IF_OSC |=> IF_CTRL.vco_drive_level == $past(st.shift[9:8]))
    else $error("VCO level not loaded from bits 9:8");

  a_test_route: assert property (
    le_rise && st.shift[2:0] == 3'h3 && !DEFAULT_COUNTER_SELECT
    |=> WRITE_TEST && TEST_WORD == $past(st.shift))
    else $error("word ending in 011 not stored as test word");

  a_test_ignored: assert property (
    le_rise && DEFAULT_COUNTER_SELECT |=> !WRITE_TEST && $stable(TEST_WORD))
    else $error("test word changed while built-in counters selected");

  a_fb_route: assert property (
    le_rise && st.shift[3:0] == 4'h7 && !DEFAULT_COUNTER_SELECT |=> WRITE_FB && FB_COUNT_OVERRIDE)
    else $error("word ending in 0111 not routed to feedback counters");

  a_fb_fields: assert property (
    le_rise && target == SSC_TGT_FB && !DEFAULT_COUNTER_SELECT
    |=> FB_COUNT.b_count == $past(st.shift[12:4]) && FB_COUNT.a_count == $past(st.shift[16:13]))
    else $error("feedback counter fields misplaced");

  a_fb_ignored: assert property (
    le_rise && DEFAULT_COUNTER_SELECT |=> !WRITE_FB && $stable(FB_COUNT))
    else $error("feedback counters changed while built-in counters selected");

  a_default_wins: assert property (
    DEFAULT_COUNTER_SELECT |-> !FB_COUNT_OVERRIDE)
    else $error("user counters used while built-in counters selected");

  a_longest_prefix: assert property (
    le_rise && st.shift[4:0] == 5'h0f |=> !WRITE_FB && !WRITE_TEST && !WRITE_IF_OSC)
    else $error("longer address code taken for a shorter one");

  a_if_dcs_free: assert property (
    le_rise && target == SSC_TGT_IF_OSC && DEFAULT_COUNTER_SELECT |=> WRITE_IF_OSC)
    else $error("IF control word refused while built-in counters selected");

  // Strobes are single pulses while CE stays high, and never two at once
  a_if_strobe_pulse: assert property (
    WRITE_IF_OSC && CE |=> !WRITE_IF_OSC)
    else $error("IF control strobe longer than one cycle");

  a_test_strobe_pulse: assert property (
    WRITE_TEST && CE |=> !WRITE_TEST)
    else $error("test word strobe longer than one cycle");

  a_fb_strobe_pulse: assert property (
    WRITE_FB && CE |=> !WRITE_FB)
    else $error("feedback counter strobe longer than one cycle");

  a_strobe_onehot: assert property (
    $onehot0({WRITE_IF_OSC, WRITE_TEST, WRITE_FB}))
    else $error("more than one word written by one latch");

  a_unknown_ignored: assert property (
    le_rise && target == SSC_TGT_NONE |=> !WRITE_IF_OSC && !WRITE_TEST && !WRITE_FB)
    else $error("word with unknown address produced a write");

  // IF controls, test word and feedback counters move only on an accepted write of their own word
  a_if_kept: assert property (
    !(le_rise && target == SSC_TGT_IF_OSC) |=> $stable(IF_CTRL))
    else $error("IF controls changed without their word");

  a_test_kept: assert property (
    !(le_rise && target == SSC_TGT_TEST && !DEFAULT_COUNTER_SELECT) |=> $stable(TEST_WORD))
    else $error("test word changed without an accepted write");

  a_fb_kept: assert property (
    !(le_rise && target == SSC_TGT_FB && !DEFAULT_COUNTER_SELECT) |=> $stable(FB_COUNT))
    else $error("feedback counters changed without an accepted write");

  a_valid_sticky: assert property (
    TEST_WORD_VALID |=> TEST_WORD_VALID)
    else $error("test word valid flag dropped without reset");

  a_pattern_flag: assert property (
    TEST_PATTERN_OK |-> TEST_WORD_VALID && TEST_WORD == `SSC_TEST_PATTERN)
    else $error("pattern flag set for a word that is not the pattern");

  // Shift register holds while the latch is high or the clock enable is low
  a_latched_hold: assert property (
    le_s |=> $stable(st.shift))
    else $error("word shifted while latch high");

  a_ce_hold: assert property (
    !CE |=> $stable(st.shift) && $stable(IF_CTRL) && $stable(FB_COUNT) && $stable(TEST_WORD))
    else $error("state moved while clock enable low");

  c_if_osc_write: cover property (le_rise && target == SSC_TGT_IF_OSC ##1 WRITE_IF_OSC);
  c_test_write: cover property (WRITE_TEST ##1 TEST_PATTERN_OK);
  c_fb_write: cover property (WRITE_FB ##1 FB_COUNT_OVERRIDE);
  c_fb_ignored: cover property (le_rise && target == SSC_TGT_FB && DEFAULT_COUNTER_SELECT);
  c_ce_pause: cover property (!CE ##1 CE);

endmodule : ssc_ctrl_words

// ===== core/ssc_params.svh
/*
  Bit positions, address codes and reset values for the serial control-word decoder.
  Assumes the words are 24 bits, most significant bit shifted in first, address in the low bits.
*/
`ifndef SSC_PARAMS_SVH
`define SSC_PARAMS_SVH

// Word geometry
`define SSC_WORD_W 24
`define SSC_WORD_MSB 23

// Address codes, longest first
`define SSC_FB_ADDR_W 4
`define SSC_FB_ADDR 4'h7
`define SSC_TEST_ADDR_W 3
`define SSC_TEST_ADDR 3'h3
`define SSC_IF_OSC_ADDR_W 2
`define SSC_IF_OSC_ADDR 2'h2

// IF and oscillator control word fields
`define SSC_IF_EN_BIT 2
`define SSC_GAIN_LSB 3
`define SSC_FIXED_IF_LSB 5
`define SSC_REF_OSC_BIT 7
`define SSC_VCO_LSB 8

// Feedback counter word fields
`define SSC_B_LSB 4
`define SSC_B_W 9
`define SSC_A_LSB 13
`define SSC_A_W 4

// Fixed test pattern
`define SSC_TEST_PATTERN 24'h00_1493

// Reset values
`define SSC_IF_EN_RESET 1'h0
`define SSC_GAIN_RESET 2'h0
`define SSC_FIXED_IF_RESET 2'h1
`define SSC_REF_OSC_RESET 1'h0
`define SSC_VCO_RESET 2'h3
`define SSC_TEST_RESET 24'h00_0000
`define SSC_B_RESET 9'h000
`define SSC_A_RESET 4'h0

`endif

// ===== core/ssc_pkg.sv
/*
  Types shared by the serial control-word decoder.
  Assumes the constants header sits beside it.
*/
`include "ssc_params.svh"

package ssc_pkg;

  // Decoded target of a latched word
  typedef enum logic [1:0] {
    SSC_TGT_NONE,
    SSC_TGT_IF_OSC,
    SSC_TGT_TEST,
    SSC_TGT_FB
  } ssc_target_type;

  // IF synthesizer and oscillator settings
  typedef struct packed {
    logic if_enable;
    logic [1:0] if_pump_gain_sel;
    logic [1:0] fixed_if_select;
    logic ref_osc_select;
    logic [1:0] vco_drive_level;
  } ssc_if_ctrl_type;

  // IF feedback divider counters
  typedef struct packed {
    logic [`SSC_A_W-1:0] a_count;
    logic [`SSC_B_W-1:0] b_count;
  } ssc_fb_count_type;

  // Whole state of the decoder
  typedef struct packed {
    logic sclk_q;
    logic le_q;
    logic [`SSC_WORD_W-1:0] shift;
    ssc_if_ctrl_type ctrl;
    logic [`SSC_WORD_W-1:0] test_word;
    logic test_valid;
    ssc_fb_count_type fb;
    logic fb_loaded;
    logic wr_if_osc;
    logic wr_test;
    logic wr_fb;
    ssc_target_type last_target;
  } ssc_state_type;

endpackage : ssc_pkg

// ===== core/ssc_pin_sync.sv
/*
  Two-stage synchroniser for a group of pin inputs.
  Assumes a reset already released synchronously to clk; ce freezes both stages.
*/
`timescale 1ns/10ps

module ssc_pin_sync import ssc_pkg::*; #(
  parameter int WIDTH = 3
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Pins and their synchronised copy
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_sync
);

  logic [WIDTH-1:0] stage1;

  // One pair of flops per pin; stage1 feeds nothing but stage2
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        stage1[i] <= 1'b0;
        pin_sync[i] <= 1'b0;
      end else if (ce) begin
        stage1[i] <= pin_in[i];
        pin_sync[i] <= stage1[i];
      end
    end
  end

endmodule : ssc_pin_sync

// ===== verif/ssc_host_model.sv
/*
  Host model that writes 24-bit control words over the three serial pins.
  Assumes the bench calls send_word only once reset has settled.
*/
`timescale 1ns/10ps

module ssc_host_model (
  // Clock
  input wire logic clk,
  // Serial pins
  output logic ser_clk,
  output logic ser_data,
  output logic ser_latch
);
  // Idle: clock low, latch high
  initial begin
    ser_clk = 1'b0;
    ser_data = 1'b0;
    ser_latch = 1'b1;
  end

  // Five cycles low and four high a phase, so the pin synchroniser never misses a bit
  task automatic send_word(input logic [23:0] word);
    @(posedge clk);
    ser_latch <= 1'b0;
    for (int i = 23; i >= 0; i--) begin
      @(posedge clk);
      ser_data <= word[i];
      repeat (4) @(posedge clk);
      ser_clk <= 1'b1;
      repeat (4) @(posedge clk);
      ser_clk <= 1'b0;
    end
    // Data no longer held, so show the inverse of the last bit
    repeat (4) @(posedge clk);
    ser_data <= ~word[0];
    ser_latch <= 1'b1;
    repeat (10) @(posedge clk);
  endtask : send_word
endmodule : ssc_host_model

// ===== verif/test_ssc_ctrl_words.sv
/*
  Self-checking bench for the serial control-word decoder.
  Assumes the host model file and the design files are compiled first.
*/
`timescale 1ns/10ps

module test_ssc_ctrl_words import ssc_pkg::*;;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic dcs = 1'b0;
  logic ser_clk, ser_data, ser_latch;
  ssc_if_ctrl_type if_ctrl;
  ssc_fb_count_type fb_count;
  logic [23:0] test_word;
  logic test_valid, test_ok, fb_over, wr_if, wr_test, wr_fb;
  int n_if = 0;
  int n_test = 0;
  int n_fb = 0;
  int miscompares = 0;
  int num_checks = 0;

  // 100 MHz clock
  always #5 clk = ~clk;

  ssc_host_model host (.clk(clk), .ser_clk(ser_clk), .ser_data(ser_data), .ser_latch(ser_latch));

  ssc_ctrl_words DUT (
    .CLK(clk), .RST_N(rst_n), .CE(ce),
    .SER_CLK(ser_clk), .SER_DATA(ser_data), .SER_LATCH(ser_latch),
    .DEFAULT_COUNTER_SELECT(dcs), .IF_CTRL(if_ctrl),
    .TEST_WORD(test_word), .TEST_WORD_VALID(test_valid), .TEST_PATTERN_OK(test_ok),
    .FB_COUNT(fb_count), .FB_COUNT_OVERRIDE(fb_over),
    .WRITE_IF_OSC(wr_if), .WRITE_TEST(wr_test), .WRITE_FB(wr_fb)
  );

  // Count strobe cycles, so a pulse longer than one cycle shows up
  always @(posedge clk) begin
    if (wr_if === 1'b1) n_if++;
    if (wr_test === 1'b1) n_test++;
    if (wr_fb === 1'b1) n_fb++;
  end

  task automatic check(input logic [23:0] seen, input logic [23:0] exp, input string msg);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check

  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_sim

  // One word, then the strobe counts it must have produced
  task automatic put(input logic [23:0] w, input int ei, input int et, input int ef);
    int b_i, b_t, b_f;
    b_i = n_if;
    b_t = n_test;
    b_f = n_fb;
    host.send_word(w);
    check(24'(n_if - b_i), 24'(ei), "if strobe");
    check(24'(n_test - b_t), 24'(et), "test strobe");
    check(24'(n_fb - b_f), 24'(ef), "fb strobe");
  endtask : put

  task automatic t_if_osc;
    ssc_if_ctrl_type e;
    for (int k = 0; k < 4; k++) begin
      e = {k[0], k[1:0], (k == 3) ? 2'b10 : k[1:0], k[0], k[1:0]};
      @(posedge clk);
      dcs <= k[0];
      put({14'h2aaa, e.vco_drive_level, e.ref_osc_select, e.fixed_if_select, e.if_pump_gain_sel,
           e.if_enable, 2'b10}, 1, 0, 0);
      check(24'(if_ctrl), 24'(e), "if fields");
    end
    $display("test if_osc done");
  endtask : t_if_osc

  task automatic t_test_word;
    @(posedge clk);
    dcs <= 1'b1;
    put(`SSC_TEST_PATTERN, 0, 0, 0);
    check(24'(test_valid), 24'h00_0000, "test ignored");
    @(posedge clk);
    dcs <= 1'b0;
    put(`SSC_TEST_PATTERN, 0, 1, 0);
    check(test_word, `SSC_TEST_PATTERN, "test word");
    check(24'({test_valid, test_ok}), 24'h00_0003, "test flags");
    $display("test test_word done");
  endtask : t_test_word

  task automatic t_feedback;
    @(posedge clk);
    dcs <= 1'b0;
    put({7'h00, 4'hf, 9'h1ff, 4'h7}, 0, 0, 1);
    check(24'(fb_count), 24'h00_1fff, "fb max");
    check(24'(fb_over), 24'h00_0001, "override on");
    put({7'h00, 4'h0, 9'h002, 4'h7}, 0, 0, 1);
    check(24'(fb_count), 24'h00_0002, "fb low");
    @(posedge clk);
    dcs <= 1'b1;
    put({7'h00, 4'h5, 9'h0aa, 4'h7}, 0, 0, 0);
    check(24'(fb_count), 24'h00_0002, "fb ignored");
    check(24'(fb_over), 24'h00_0000, "override off");
    $display("test feedback done");
  endtask : t_feedback

  // Longer codes of other words must not be taken for these
  task automatic t_prefix;
    @(posedge clk);
    dcs <= 1'b0;
    put(24'h00_210f, 0, 0, 0);
    put(24'h01_fff7 | 24'h00_0038, 0, 0, 0);
    put(24'h68_a8a5, 0, 0, 0);
    check(24'(fb_count), 24'h00_0002, "fb kept");
    check(24'(if_ctrl), 24'h00_00f7, "if kept");
    $display("test prefix done");
  endtask : t_prefix

  // Clock enable low freezes the decoder, so a whole word passes unseen
  task automatic t_clock_enable;
    @(posedge clk);
    ce <= 1'b0;
    put({14'h0000, 2'b00, 1'b1, 2'b00, 2'b01, 1'b1, 2'b10}, 0, 0, 0);
    @(posedge clk);
    ce <= 1'b1;
    repeat (6) @(posedge clk);
    check(24'(if_ctrl), 24'h00_00f7, "ce frozen");
    $display("test clock_enable done");
  endtask : t_clock_enable

  // Reset in mid-run restores every output, and words land again afterwards
  task automatic t_mid_reset;
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    check(24'(if_ctrl), 24'h00_000b, "reset ctrl again");
    check(24'({test_valid, test_ok, fb_over}), 24'h00_0000, "reset flags again");
    check(24'(fb_count), 24'h00_0000, "reset counters");
    check(test_word, 24'h00_0000, "reset test word");
    put(24'h00_0386, 1, 0, 0);
    check(24'(if_ctrl), 24'h00_0087, "if after reset");
    $display("test mid_reset done");
  endtask : t_mid_reset

  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    check(24'(if_ctrl), 24'h00_000b, "reset ctrl");
    check(24'({test_valid, fb_over}), 24'h00_0000, "reset flags");
    t_if_osc();
    t_test_word();
    t_feedback();
    t_prefix();
    t_clock_enable();
    t_mid_reset();
    end_sim();
  end

  // Watchdog: 20000 cycles, some six times the 14 words of some 240 cycles each
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    end_sim();
  end
endmodule : test_ssc_ctrl_words
